//--- hw/tft_pkg.sv
`default_nettype none
package tft_pkg;
  // timing
  localparam int unsigned TFT_CLK_HZ     = 125_000_000;
  localparam int unsigned TFT_CYC_PER_MS = TFT_CLK_HZ / 1000;
  localparam int unsigned TFT_LONG_MS    = 5000;
  localparam int unsigned TFT_SHORT_MS   = 1000;
  localparam int unsigned TFT_DEB_MS     = 10;
  localparam int unsigned TFT_LONG_CYC   = TFT_LONG_MS * TFT_CYC_PER_MS;
  localparam int unsigned TFT_SHORT_CYC  = TFT_SHORT_MS * TFT_CYC_PER_MS;
  localparam int unsigned TFT_DEB_CYC    = TFT_DEB_MS * TFT_CYC_PER_MS;
  localparam int          TFT_HOLD_W     = 30;
  localparam int          TFT_DEB_W      = 21;
  // sizes
  localparam int TFT_NSTG  = 4;
  localparam int TFT_NOUT  = 2 * TFT_NSTG;
  localparam int TFT_NREL  = 3;
  localparam int TFT_POS_W = 4;
  localparam int TFT_NBTN  = 3;
  localparam int TFT_NEV   = 4;
  localparam int TFT_CODE_W = 12;
  // button index
  localparam int TFT_BTN_PROG  = 0;
  localparam int TFT_BTN_STEP  = 1;
  localparam int TFT_BTN_RESET = 2;
  // positions and routing
  localparam logic [TFT_POS_W-1:0] TFT_POS_FLT  = 4'h0;
  localparam logic [TFT_POS_W-1:0] TFT_POS_LAST = 4'h8;
  localparam logic [TFT_NOUT-1:0]  TFT_TRIP_SEL = 8'hAA;
  localparam int                   TFT_MAIN_REL = 0;
  // status event bits
  localparam int TFT_EV_ENTER = 0;
  localparam int TFT_EV_EXIT  = 1;
  localparam int TFT_EV_FAULT = 2;
  localparam int TFT_EV_OPER  = 3;
  // register byte offsets
  localparam logic [7:0] TFT_OFS_MATRIX = 8'h00;
  localparam logic [7:0] TFT_OFS_STATUS = 8'h04;
  localparam logic [7:0] TFT_OFS_MASK   = 8'h08;
  localparam logic [7:0] TFT_OFS_STATE  = 8'h0C;
  localparam logic [7:0] TFT_OFS_FAULT  = 8'h10;
  localparam logic [7:0] TFT_OFS_OPIND  = 8'h14;
  // serial variable number of the fault code
  localparam logic [7:0] TFT_FAULT_VAR  = 8'hA9;
  // reset values
  localparam logic TFT_RST_HREADY = 1'h1;

  typedef enum logic [0:0] {
    TFT_MODE_NORM = 1'h0,
    TFT_MODE_TEST = 1'h1
  } tft_mode_e;

  typedef enum logic [1:0] {
    TFT_IND_NONE  = 2'h0,
    TFT_IND_START = 2'h1,
    TFT_IND_OPER  = 2'h2
  } tft_ind_e;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } tft_ahb_req_s;

  typedef struct packed {
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
  } tft_ahb_rsp_s;

  typedef struct packed {
    logic [TFT_NBTN-1:0][2:0]           sync;
    logic [TFT_NBTN-1:0]                deb;
    logic [TFT_NBTN-1:0]                deb_d;
    logic [TFT_NBTN-1:0][TFT_DEB_W-1:0] dcnt;
    logic [TFT_HOLD_W-1:0]              pcnt;
    logic [TFT_HOLD_W-1:0]              scnt;
    logic                               combo;
    tft_mode_e                          mode;
    logic [TFT_POS_W-1:0]               pos;
    logic [TFT_NOUT-1:0]                set_ind;
    logic [TFT_NOUT-1:0]                forced;
    logic                               flt_out;
    logic [TFT_NREL-1:0]                relay;
    logic                               trip_led;
    tft_ind_e [TFT_NSTG-1:0]            op_ind;
    logic                               fault;
    logic [TFT_CODE_W-1:0]              code;
    logic [TFT_NREL-1:0][TFT_NOUT-1:0]  matrix;
    logic [TFT_NEV-1:0]                 status;
    logic [TFT_NEV-1:0]                 mask;
    logic                               irq;
    logic                               pend;
    logic                               pwrite;
    logic                               pok;
    logic [7:0]                         paddr;
    logic                               hready;
    logic [31:0]                        rdata;
  } tft_state_s;
endpackage
`default_nettype wire

//--- hw/tft_trip_test.sv
// Behaviour
// - five second program hold enters test, digits flash
// - step held one second forces internal fault
// - one second program press selects first start
// - program plus step forces selection through matrix
// - each one second press advances to next position
// - forced trip on main relay lights trip
// - program again skips position without forcing it
// - five second hold leaves test, flashing stops
// - indicator shows start code, then operate code
// - indicator latched until reset button, no effect
// - permanent fault lights led and fault output
// - fault code shown, reset button keeps it
// - fault inhibits protection, registers stay usable
// - code held while fault, readable by software
// - forcing lasts only while both buttons held
// - order: start then trip, fault without indicator
//
// The address map and the AHB-Lite slave port were chosen for this implementation.
`default_nettype none
module tft_trip_test
  import tft_pkg::*;
#(
  parameter int unsigned P_LONG_CYC  = TFT_LONG_CYC,
  parameter int unsigned P_SHORT_CYC = TFT_SHORT_CYC,
  parameter int unsigned P_DEB_CYC   = TFT_DEB_CYC
) (
  input  wire logic                          i_clock,
  input  wire logic                          i_rst,
  input  wire logic                          i_btn_prog,
  input  wire logic                          i_btn_step,
  input  wire logic                          i_btn_reset,
  input  wire logic [TFT_NSTG-1:0]           i_stage_start,
  input  wire logic [TFT_NSTG-1:0]           i_stage_trip,
  input  wire logic                          i_fault,
  input  wire logic [TFT_CODE_W-1:0]         i_fault_code,
  input  wire tft_ahb_req_s                  i_ahb,
  output var  tft_ahb_rsp_s                  o_ahb,
  output var  logic                          o_flash_digits,
  output var  logic [TFT_NOUT-1:0]           o_set_ind,
  output var  logic                          o_internal_fault_led,
  output var  logic                          o_internal_fault_output,
  output var  logic [TFT_NREL-1:0]           o_relay,
  output var  logic                          o_trip_led,
  output var  tft_ind_e [TFT_NSTG-1:0]       o_op_ind,
  output var  logic                          o_fault_show,
  output var  logic [TFT_CODE_W-1:0]         o_fault_code,
  output var  logic                          o_irq
);

  localparam logic [TFT_HOLD_W-1:0] LONG_LIM  = TFT_HOLD_W'(P_LONG_CYC);
  localparam logic [TFT_HOLD_W-1:0] SHORT_LIM = TFT_HOLD_W'(P_SHORT_CYC);
  localparam logic [TFT_DEB_W-1:0]  DEB_LIM   = TFT_DEB_W'(P_DEB_CYC - 1);

  tft_state_s          s_r;
  tft_state_s          s_nxt;
  logic [TFT_NBTN-1:0] btn;
  logic                prog_w;
  logic                step_w;
  logic                long_evt;
  logic                adv;
  logic                rst_rise;

  assign btn = {i_btn_reset, i_btn_step, i_btn_prog};

  // one-hot setting indicator of a position, none for internal fault
  function automatic logic [TFT_NOUT-1:0] pos_dec(
    input logic [TFT_POS_W-1:0] p
  );
    logic [TFT_NOUT-1:0] d;
    d = '0;
    for (int i = 0; i < TFT_NOUT; i++) begin
      d[i] = (p == TFT_POS_W'(i + 1));
    end
    return d;
  endfunction

  // output relays as the matrix routes the signals
  function automatic logic [TFT_NREL-1:0] route(
    input logic [TFT_NREL-1:0][TFT_NOUT-1:0] m,
    input logic [TFT_NOUT-1:0]               sg
  );
    logic [TFT_NREL-1:0] r;
    r = '0;
    for (int k = 0; k < TFT_NREL; k++) begin
      r[k] = |(m[k] & sg);
    end
    return r;
  endfunction

  always_comb begin
    logic                flt_now;
    logic                test;
    logic                prel;
    logic [TFT_NOUT-1:0] sig;
    logic [TFT_NEV-1:0]  ev;
    logic [TFT_NEV-1:0]  w1c;
    flt_now = 1'b0;
    test    = 1'b0;
    prel    = 1'b0;
    sig     = '0;
    ev      = '0;
    w1c     = '0;
    s_nxt   = s_r;

    // synchronise and debounce the buttons
    for (int b = 0; b < TFT_NBTN; b++) begin
      s_nxt.sync[b] = {s_r.sync[b][1:0], btn[b]};
      if (s_r.sync[b][2] == s_r.sync[b][1] &&
          s_r.sync[b][2] != s_r.deb[b]) begin
        if (s_r.dcnt[b] >= DEB_LIM) begin
          s_nxt.deb[b]  = s_r.sync[b][2];
          s_nxt.dcnt[b] = '0;
        end else begin
          s_nxt.dcnt[b] = s_r.dcnt[b] + 1'b1;
        end
      end else begin
        s_nxt.dcnt[b] = '0;
      end
    end
    s_nxt.deb_d = s_r.deb;
    prog_w   = s_r.deb[TFT_BTN_PROG];
    step_w   = s_r.deb[TFT_BTN_STEP];
    rst_rise = s_r.deb[TFT_BTN_RESET] & ~s_r.deb_d[TFT_BTN_RESET];
    prel     = s_r.deb_d[TFT_BTN_PROG] & ~prog_w;

    // hold time counters
    if (!prog_w) begin
      s_nxt.pcnt = '0;
    end else if (s_r.pcnt != LONG_LIM) begin
      s_nxt.pcnt = s_r.pcnt + 1'b1;
    end
    if (!step_w) begin
      s_nxt.scnt = '0;
    end else if (s_r.scnt != SHORT_LIM) begin
      s_nxt.scnt = s_r.scnt + 1'b1;
    end
    long_evt    = prog_w && (s_r.pcnt == LONG_LIM - 1'b1);
    s_nxt.combo = prog_w & (s_r.combo | step_w);
    adv = prel && !s_r.combo &&
          (s_r.pcnt >= SHORT_LIM) && (s_r.pcnt < LONG_LIM);

    // test sequencer
    case (s_r.mode)
      TFT_MODE_NORM: begin
        if (long_evt) begin
          s_nxt.mode       = TFT_MODE_TEST;
          s_nxt.pos        = TFT_POS_FLT;
          ev[TFT_EV_ENTER] = 1'b1;
        end
      end
      TFT_MODE_TEST: begin
        if (long_evt) begin
          s_nxt.mode      = TFT_MODE_NORM;
          s_nxt.pos       = TFT_POS_FLT;
          ev[TFT_EV_EXIT] = 1'b1;
        end else if (adv) begin
          if (s_r.pos == TFT_POS_LAST) begin
            s_nxt.pos = TFT_POS_FLT;
          end else begin
            s_nxt.pos = s_r.pos + 1'b1;
          end
        end
      end
      default: begin
        s_nxt.mode = TFT_MODE_NORM;
        s_nxt.pos  = TFT_POS_FLT;
      end
    endcase
    test = (s_r.mode == TFT_MODE_TEST);
    s_nxt.set_ind = (s_nxt.mode == TFT_MODE_TEST) ?
                    pos_dec(s_nxt.pos) : '0;

    // forcing
    if (test && prog_w && step_w && s_r.pos != TFT_POS_FLT) begin
      s_nxt.forced = pos_dec(s_r.pos);
    end else begin
      s_nxt.forced = '0;
    end
    flt_now = test && (s_r.pos == TFT_POS_FLT) && step_w &&
              !prog_w && (s_r.scnt == SHORT_LIM);
    s_nxt.flt_out = flt_now | i_fault;

    // self-supervision fault
    s_nxt.fault = i_fault;
    s_nxt.code  = i_fault ? i_fault_code : '0;
    ev[TFT_EV_FAULT] = i_fault & ~s_r.fault;

    // relay drive, protection inhibited during a fault
    for (int i = 0; i < TFT_NSTG; i++) begin
      sig[2*i]   = i_stage_start[i] & ~s_r.fault;
      sig[2*i+1] = i_stage_trip[i] & ~s_r.fault;
    end
    sig = sig | s_r.forced;
    s_nxt.relay = route(s_r.matrix, sig);

    if (|(s_r.forced & TFT_TRIP_SEL) && s_nxt.relay[TFT_MAIN_REL]) begin
      s_nxt.trip_led = 1'b1;
    end else if (rst_rise) begin
      s_nxt.trip_led = 1'b0;
    end

    // operation indicators
    for (int i = 0; i < TFT_NSTG; i++) begin
      if (i_stage_trip[i]) begin
        s_nxt.op_ind[i] = TFT_IND_OPER;
        if (s_r.op_ind[i] != TFT_IND_OPER) begin
          ev[TFT_EV_OPER] = 1'b1;
        end
      end else if (i_stage_start[i] &&
                   s_r.op_ind[i] == TFT_IND_NONE) begin
        s_nxt.op_ind[i] = TFT_IND_START;
      end else if (rst_rise) begin
        s_nxt.op_ind[i] = TFT_IND_NONE;
      end
    end

    // register bus slave, one wait state per transfer
    if (!s_r.pend) begin
      s_nxt.hready = 1'b1;
      if (i_ahb.hsel && i_ahb.htrans[1] && i_ahb.hready) begin
        s_nxt.pend   = 1'b1;
        s_nxt.pwrite = i_ahb.hwrite;
        s_nxt.paddr  = i_ahb.haddr[7:0];
        s_nxt.pok    = (i_ahb.haddr[31:8] == 24'h000000);
        s_nxt.hready = 1'b0;
      end
    end else begin
      s_nxt.pend   = 1'b0;
      s_nxt.hready = 1'b1;
      s_nxt.rdata  = '0;
      if (s_r.pwrite && s_r.pok) begin
        case (s_r.paddr)
          TFT_OFS_MATRIX: s_nxt.matrix = i_ahb.hwdata[23:0];
          TFT_OFS_STATUS: w1c = i_ahb.hwdata[TFT_NEV-1:0];
          TFT_OFS_MASK:   s_nxt.mask = i_ahb.hwdata[TFT_NEV-1:0];
          default: ;
        endcase
      end else if (s_r.pok) begin
        case (s_r.paddr)
          TFT_OFS_MATRIX: s_nxt.rdata = {8'h00, s_r.matrix};
          TFT_OFS_STATUS: s_nxt.rdata = {28'h0000000, s_r.status};
          TFT_OFS_MASK:   s_nxt.rdata = {28'h0000000, s_r.mask};
          TFT_OFS_STATE:  s_nxt.rdata = {16'h0000, s_r.forced,
                                         s_r.pos, s_r.trip_led,
                                         s_r.flt_out, s_r.fault,
                                         s_r.mode};
          TFT_OFS_FAULT:  s_nxt.rdata = {8'h00, TFT_FAULT_VAR,
                                         3'h0, s_r.fault,
                                         s_r.code};
          TFT_OFS_OPIND:  s_nxt.rdata = {24'h000000, s_r.op_ind};
          default:        s_nxt.rdata = '0;
        endcase
      end
    end

    // sticky events, set wins over clear
    s_nxt.status = (s_r.status & ~w1c) | ev;
    s_nxt.irq    = |(s_nxt.status & s_nxt.mask);
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      s_r        <= '0;
      s_r.hready <= TFT_RST_HREADY;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_ahb.hreadyout = s_r.hready;
  assign o_ahb.hresp     = 1'b0;
  assign o_ahb.hrdata    = s_r.rdata;
  assign o_flash_digits  = s_r.mode;
  assign o_set_ind       = s_r.set_ind;
  assign o_internal_fault_led    = s_r.flt_out;
  assign o_internal_fault_output = s_r.flt_out;
  assign o_relay         = s_r.relay;
  assign o_trip_led      = s_r.trip_led;
  assign o_op_ind        = s_r.op_ind;
  assign o_fault_show    = s_r.fault;
  assign o_fault_code    = s_r.code;
  assign o_irq           = s_r.irq;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  enter_test_a: assert property (
    s_r.mode == TFT_MODE_NORM && long_evt |=> o_flash_digits
  ) else $error("test mode not entered after long hold");

  exit_test_a: assert property (
    s_r.mode == TFT_MODE_TEST && long_evt
    |=> !o_flash_digits && o_set_ind == 8'h00
  ) else $error("test mode not left after long hold");

  flt_hold_a: assert property (
    $rose(o_internal_fault_output) && !$past(i_fault)
    |-> $past(step_w) && $past(s_r.scnt) == SHORT_LIM
  ) else $error("fault output forced without one second step hold");

  flt_drop_a: assert property (
    !step_w && !i_fault |=> !o_internal_fault_output
  ) else $error("fault output stayed after step release");

  first_pos_a: assert property (
    s_r.mode == TFT_MODE_TEST && adv && s_r.pos == TFT_POS_FLT
    |=> ##1 o_set_ind == 8'h01
  ) else $error("first start position not selected");

  advance_a: assert property (
    s_r.mode == TFT_MODE_TEST && adv && s_r.pos != TFT_POS_LAST
    |=> s_r.pos == $past(s_r.pos) + 4'h1 && s_r.forced == 8'h00
  ) else $error("position did not advance by one");

  force_a: assert property (
    s_r.forced != 8'h00 |-> $past(prog_w) && $past(step_w)
  ) else $error("output forced without both buttons");

  route_a: assert property (
    |(s_r.forced & s_r.matrix[TFT_MAIN_REL]) |=> o_relay[TFT_MAIN_REL]
  ) else $error("forced signal not routed to relay");

  trip_led_a: assert property (
    |(s_r.forced & TFT_TRIP_SEL & s_r.matrix[TFT_MAIN_REL])
    |=> o_trip_led
  ) else $error("trip indicator not lit by forced trip");

  oper_a: assert property (
    i_stage_trip[0] |=> o_op_ind[0] == TFT_IND_OPER
  ) else $error("operate code not shown");

  latch_a: assert property (
    o_op_ind[0] == TFT_IND_OPER && !rst_rise
    |=> o_op_ind[0] == TFT_IND_OPER
  ) else $error("operation indicator lost without reset");

  fault_a: assert property (
    i_fault
    |=> o_internal_fault_led && o_internal_fault_output && o_fault_show
  ) else $error("fault not indicated");

  code_a: assert property (
    i_fault && rst_rise |=> o_fault_show
  ) else $error("reset button removed fault code");

  inhibit_a: assert property (
    s_r.fault && s_r.forced == 8'h00 |=> o_relay == 3'h0
  ) else $error("protection not inhibited in fault");

  code_keep_a: assert property (
    i_fault |=> o_fault_code == $past(i_fault_code)
  ) else $error("fault code not held");

endmodule
`default_nettype wire

//--- tb/tft_operator.sv
`default_nettype none
module tft_operator (
  input  wire logic i_clock,
  output var  logic o_prog,
  output var  logic o_step,
  output var  logic o_reset
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] btn_r;
  assign o_prog  = btn_r[0];
  assign o_step  = btn_r[1];
  assign o_reset = btn_r[2];
  initial btn_r = 3'h0;
  // contacts bounce once before settling
  task automatic down(input int b);
    @(posedge i_clock) btn_r[b] <= 1'b1;
    @(posedge i_clock) btn_r[b] <= 1'b0;
    @(posedge i_clock) btn_r[b] <= 1'b1;
  endtask
  // release, then give the debounce time to see it
  task automatic up(input int b);
    @(posedge i_clock) btn_r[b] <= 1'b0;
    repeat (20) @(posedge i_clock);
  endtask
  task automatic press(input int b, input int n);
    down(b);
    repeat (n) @(posedge i_clock);
    up(b);
  endtask
endmodule
`default_nettype wire

//--- tb/trip_test_and_fault_indication_tb.sv
`default_nettype none
module trip_test_and_fault_indication_tb
  import tft_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LONG  = 200;
  localparam int SHORT = 40;
  localparam int PR    = TFT_BTN_PROG;
  logic                 i_clock;
  logic                 i_rst;
  logic                 prog;
  logic                 step;
  logic                 rbtn;
  logic [3:0]           start;
  logic [3:0]           trip;
  logic                 fault;
  logic [11:0]          code;
  tft_ahb_req_s         req_r;
  tft_ahb_req_s         req;
  tft_ahb_rsp_s         rsp;
  logic                 flash;
  logic [7:0]           set_ind;
  logic                 flt_led;
  logic                 flt_out;
  logic [2:0]           relay;
  logic                 trip_led;
  tft_ind_e [3:0]       op_ind;
  logic                 show;
  logic [11:0]          code_o;
  logic                 irq;
  logic [31:0]          v;
  int                   errors;
  int                   checks_done;

  always_comb begin
    req = req_r;
    req.hready = rsp.hreadyout;
  end

  initial begin
    i_clock = 1'b0;
    forever #4 i_clock = ~i_clock;
  end

  tft_operator tft_operator_inst (
    .i_clock(i_clock), .o_prog(prog), .o_step(step), .o_reset(rbtn)
  );

  tft_trip_test #(.P_LONG_CYC(LONG), .P_SHORT_CYC(SHORT), .P_DEB_CYC(4))
  tft_trip_test_inst (
    .i_clock(i_clock), .i_rst(i_rst), .i_btn_prog(prog),
    .i_btn_step(step), .i_btn_reset(rbtn), .i_stage_start(start),
    .i_stage_trip(trip), .i_fault(fault), .i_fault_code(code),
    .i_ahb(req), .o_ahb(rsp), .o_flash_digits(flash),
    .o_set_ind(set_ind), .o_internal_fault_led(flt_led),
    .o_internal_fault_output(flt_out),
    .o_relay(relay), .o_trip_led(trip_led), .o_op_ind(op_ind),
    .o_fault_show(show), .o_fault_code(code_o), .o_irq(irq)
  );

  task automatic stop_test();
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge i_clock);
      n++;
    end while (rsp.hreadyout !== 1'b1 && n < 50);
    if (rsp.hreadyout !== 1'b1) begin
      errors++;
      stop_test();
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge i_clock);
    req_r.hsel   <= 1'b1;
    req_r.htrans <= 2'h2;
    req_r.haddr  <= {24'h0, a};
    req_r.hwrite <= w;
    req_r.hsize  <= 3'h2;
    wait_rdy();
    req_r.hsel   <= 1'b0;
    req_r.htrans <= 2'h0;
    req_r.hwdata <= wd;
    wait_rdy();
    rd = rsp.hrdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    bus(1'b0, a, 32'h0, d);
    chk(d, exp);
  endtask

  // both buttons down, then step let go first
  task automatic force_chk(input logic [2:0] exp);
    tft_operator_inst.down(PR);
    tft_operator_inst.down(TFT_BTN_STEP);
    repeat (20) @(posedge i_clock);
    chk(32'(relay), 32'(exp));
    tft_operator_inst.up(TFT_BTN_STEP);
    chk(32'(relay), 32'h0);
    tft_operator_inst.up(PR);
  endtask

  initial begin
    errors = 0;
    checks_done = 0;
    i_rst = 1'b1;
    start = 4'h0;
    trip = 4'h0;
    fault = 1'b0;
    code = 12'h0;
    req_r = '0;
    repeat (16) @(posedge i_clock);
    i_rst <= 1'b0;
    rd_chk(TFT_OFS_STATE, 32'h0);
    rd_chk(8'h40, 32'h0);
    chk(32'(rsp.hresp), 32'h0);
    bus(1'b1, TFT_OFS_MATRIX, 32'h0001_55AA, v);
    rd_chk(TFT_OFS_MATRIX, 32'h0001_55AA);
    bus(1'b1, TFT_OFS_MASK, 32'h0000_000F, v);
    tft_operator_inst.press(PR, SHORT + 30);
    chk(32'(set_ind), 32'h0);
    tft_operator_inst.press(PR, LONG + 40);
    chk(32'(flash), 32'h1);
    chk(32'(set_ind), 32'h0);
    chk(32'(irq), 32'h1);
    rd_chk(TFT_OFS_STATUS, 32'h1);
    bus(1'b1, TFT_OFS_STATUS, 32'h0000_000F, v);
    repeat (3) @(posedge i_clock);
    chk(32'(irq), 32'h0);
    tft_operator_inst.down(TFT_BTN_STEP);
    repeat (20) @(posedge i_clock);
    chk(32'(flt_out), 32'h0);
    repeat (50) @(posedge i_clock);
    chk(32'({flt_led, flt_out}), 32'h3);
    tft_operator_inst.up(TFT_BTN_STEP);
    chk(32'({flt_led, flt_out}), 32'h0);
    tft_operator_inst.press(PR, SHORT + 30);
    chk(32'(set_ind), 32'h1);
    rd_chk(TFT_OFS_STATE, 32'h0000_0011);
    force_chk(3'h6);
    chk(32'(trip_led), 32'h0);
    tft_operator_inst.press(PR, SHORT + 30);
    chk(32'(set_ind), 32'h2);
    force_chk(3'h1);
    chk(32'(trip_led), 32'h1);
    tft_operator_inst.press(TFT_BTN_RESET, 10);
    chk(32'(trip_led), 32'h0);
    for (int i = 3; i <= 8; i++) begin
      tft_operator_inst.press(PR, SHORT + 30);
      chk(32'(set_ind), 32'(1) << (i - 1));
      chk(32'(relay), 32'h0);
    end
    tft_operator_inst.press(PR, SHORT + 30);
    chk(32'(set_ind), 32'h0);
    tft_operator_inst.press(PR, LONG + 40);
    chk(32'(flash), 32'h0);
    rd_chk(TFT_OFS_STATUS, 32'h2);
    @(posedge i_clock) start[1] <= 1'b1;
    repeat (5) @(posedge i_clock);
    chk(32'(op_ind[1]), 32'(TFT_IND_START));
    trip[1] <= 1'b1;
    repeat (5) @(posedge i_clock);
    chk(32'(op_ind[1]), 32'(TFT_IND_OPER));
    chk(32'(relay), 32'h3);
    rd_chk(TFT_OFS_OPIND, 32'h0000_0008);
    start[1] <= 1'b0;
    trip[1] <= 1'b0;
    repeat (5) @(posedge i_clock);
    chk(32'(op_ind[1]), 32'(TFT_IND_OPER));
    chk(32'(relay), 32'h0);
    rd_chk(TFT_OFS_STATUS, 32'hA);
    tft_operator_inst.press(TFT_BTN_RESET, 10);
    chk(32'(op_ind[1]), 32'(TFT_IND_NONE));
    fault <= 1'b1;
    code <= 12'h123;
    repeat (5) @(posedge i_clock);
    chk(32'({flt_led, flt_out}), 32'h3);
    chk(32'({show, code_o}), 32'h1123);
    trip[0] <= 1'b1;
    repeat (5) @(posedge i_clock);
    chk(32'(relay), 32'h0);
    trip[0] <= 1'b0;
    rd_chk(TFT_OFS_FAULT, 32'h00A9_1123);
    rd_chk(TFT_OFS_MATRIX, 32'h0001_55AA);
    tft_operator_inst.press(TFT_BTN_RESET, 10);
    chk(32'({show, code_o}), 32'h1123);
    chk(32'(irq), 32'h1);
    fault <= 1'b0;
    repeat (5) @(posedge i_clock);
    chk(32'(show), 32'h0);
    stop_test();
  end
endmodule
`default_nettype wire
